// file: bench/npv_ndef_pwd_props.sv
`include "npv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// ****
// Answer timing, retry and grant checks
// ****
module npv_ndef_pwd_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sessionStart,
    input wire logic fileSelEvent,
    input wire logic apduValid,
    input wire logic apduLast,
    input wire logic apduReady_q,
    input wire logic rspValid_q,
    input wire logic [7:0] rspSw1_q,
    input wire logic [7:0] rspSw2_q,
    input wire logic grantRead_q,
    input wire logic grantWrite_q,
    input wire logic [1:0] attemptsLeft_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic lastTaken = apduValid && apduReady_q && apduLast;

    property p_pulse; rspValid_q |=> !rspValid_q; endproperty
    a_pulse: assert property (p_pulse) else $error("answer pulse too long");
    property p_busy; lastTaken |=> !apduReady_q && !rspValid_q; endproperty
    a_busy: assert property (p_busy) else $error("bytes taken while evaluating");
    property p_ans; lastTaken |-> ##[2:3] rspValid_q; endproperty
    a_ans: assert property (p_ans) else $error("answer late");
    property p_hold; !rspValid_q |-> $stable({rspSw1_q, rspSw2_q}); endproperty
    a_hold: assert property (p_hold) else $error("status word moved");
    property p_dec;
        attemptsLeft_q != $past(attemptsLeft_q) && !$past(sessionStart) |-> rspValid_q &&
            attemptsLeft_q == $past(attemptsLeft_q) - 2'h1 &&
            {rspSw1_q, rspSw2_q} == {`NPV_SW_BAD_PWD, 2'h0, attemptsLeft_q};
    endproperty
    a_dec: assert property (p_dec) else $error("bad attempt count step");
    property p_zero;
        rspValid_q && $past(attemptsLeft_q) == `NPV_RETRY_NONE |->
            {rspSw1_q, rspSw2_q[7:4]} != `NPV_SW_BAD_PWD;
    endproperty
    a_zero: assert property (p_zero) else $error("check done with no attempts");
    property p_grant;
        $rose(grantRead_q) || $rose(grantWrite_q) |-> rspValid_q &&
            {rspSw1_q, rspSw2_q} == `NPV_SW_OK;
    endproperty
    a_grant: assert property (p_grant) else $error("grant without success");
    property p_sess; sessionStart |=> attemptsLeft_q == `NPV_RETRY_MAX || rspValid_q; endproperty
    a_sess: assert property (p_sess) else $error("attempts not refilled");
    property p_clear;
        sessionStart || fileSelEvent |=> rspValid_q || !(grantRead_q || grantWrite_q);
    endproperty
    a_clear: assert property (p_clear) else $error("grant kept");
endmodule : npv_ndef_pwd_props

bind npv_ndef_pwd npv_ndef_pwd_props i_npv_ndef_pwd_props (.core_clk(core_clk), .rst_n(rst_n),
    .sessionStart(sessionStart), .fileSelEvent(fileSelEvent), .apduValid(apduValid),
    .apduLast(apduLast), .apduReady_q(apduReady_q), .rspValid_q(rspValid_q),
    .rspSw1_q(rspSw1_q), .rspSw2_q(rspSw2_q), .grantRead_q(grantRead_q),
    .grantWrite_q(grantWrite_q), .attemptsLeft_q(attemptsLeft_q));

`default_nettype wire

// file: bench/npv_reader.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Reader model: hands one request to the tag byte by byte
// ****
module npv_reader (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic slow,
    input wire logic [4:0] reqLen,
    input wire logic [167:0] reqData,
    input wire logic apduReady_q,
    output logic apduValid,
    output logic [7:0] apduByte,
    output logic apduLast
);
    logic busy;
    logic [4:0] idx;
    wire logic taken = apduValid && apduReady_q;

    // Bytes held until taken; a released line shows the inverse of its last byte
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            apduValid <= 1'b0;
            apduLast <= 1'b0;
            apduByte <= 8'h00;
        end else if (go) begin
            busy <= 1'b1;
            idx <= 5'h00;
        end else if (taken && (apduLast || slow)) begin
            busy <= busy && !apduLast;
            apduValid <= 1'b0;
            apduLast <= 1'b0;
            apduByte <= ~apduByte;
        end else if (busy && (!apduValid || taken)) begin
            apduValid <= 1'b1;
            apduByte <= reqData[(20 - int'(idx)) * 8 +: 8];
            apduLast <= (idx == reqLen - 5'h01);
            idx <= idx + 5'h01;
        end
    end
endmodule : npv_reader

`default_nettype wire

// file: bench/tb_npv_ndef_pwd.sv
`include "npv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_npv_ndef_pwd;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sessionStart = 1'b0, fileSelEvent = 1'b0, fileSelected = 1'b0, fileIsNdef = 1'b0;
    logic [7:0] readAccess = 8'h00, writeAccess = 8'h00;
    logic pwdStoreFail = 1'b0, go = 1'b0, slow = 1'b0;
    logic [4:0] reqLen = 5'h05;
    logic [167:0] reqData = '0;
    logic apduValid, apduLast, apduReady_q, rspValid_q, grantRead_q, grantWrite_q;
    logic [7:0] apduByte, rspSw1_q, rspSw2_q;
    logic [1:0] attemptsLeft_q, gnt, att;
    npv_pkg::npv_pwd_t pw [2];
    logic [7:0] accR [3] = '{8'h00, 8'h80, 8'hFE};
    logic [7:0] accW [3] = '{8'h00, 8'h80, 8'hFF};
    logic [7:0] insT [3] = '{`NPV_INS_VERIFY, `NPV_INS_CHANGE, 8'hB0};
    int numErrors = 0, nCompared = 0;

    npv_ndef_pwd i_npv_ndef_pwd (.core_clk(core_clk), .rst_n(rst_n),
        .sessionStart(sessionStart), .fileSelEvent(fileSelEvent), .fileSelected(fileSelected),
        .fileIsNdef(fileIsNdef), .readAccess(readAccess), .writeAccess(writeAccess),
        .pwdStoreFail(pwdStoreFail), .apduValid(apduValid), .apduByte(apduByte),
        .apduLast(apduLast), .apduReady_q(apduReady_q), .rspValid_q(rspValid_q),
        .rspSw1_q(rspSw1_q), .rspSw2_q(rspSw2_q), .grantRead_q(grantRead_q),
        .grantWrite_q(grantWrite_q), .attemptsLeft_q(attemptsLeft_q));
    npv_reader i_npv_reader (.core_clk(core_clk), .rst_n(rst_n), .go(go), .slow(slow),
        .reqLen(reqLen), .reqData(reqData), .apduReady_q(apduReady_q),
        .apduValid(apduValid), .apduByte(apduByte), .apduLast(apduLast));

    // Free running clock
    always #50 core_clk = ~core_clk;

    // ****
    // Checking and closing
    // ****
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (exp !== got) begin
            numErrors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic closeOut();
        if (numErrors == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : closeOut

    // New selection or session; the model drops grants and may refill attempts
    task automatic env(input logic sess, input logic sel, input logic ndef,
                       input logic [7:0] ra, input logic [7:0] wa, input logic fail);
        @(posedge core_clk);
        sessionStart <= sess;
        fileSelEvent <= 1'b1;
        fileSelected <= sel;
        fileIsNdef <= ndef;
        readAccess <= ra;
        writeAccess <= wa;
        pwdStoreFail <= fail;
        @(posedge core_clk);
        sessionStart <= 1'b0;
        fileSelEvent <= 1'b0;
        gnt = 2'b00;
        if (sess) att = `NPV_RETRY_MAX;
    endtask : env

    // One request; the expected status comes from the bench model
    task automatic send(input logic [7:0] cla, input logic [7:0] ins, input logic [15:0] p12,
                        input logic [7:0] lc, input npv_pkg::npv_pwd_t dat);
        logic [15:0] exp;
        logic k;
        logic [7:0] acc;
        // Let inputs driven at the previous edge settle before modelling
        @(posedge core_clk);
        k = (p12 == `NPV_P12_WRITE);
        acc = k ? writeAccess : readAccess;
        exp = `NPV_SW_OK;
        if (cla != `NPV_CLA_ISO) exp = `NPV_SW_BAD_CLA;
        else if (ins == `NPV_INS_VERIFY) begin
            if (!fileSelected) exp = `NPV_SW_COND;
            else if (!fileIsNdef) exp = `NPV_SW_INCOMPAT;
            else if (p12 != `NPV_P12_READ && !k) exp = `NPV_SW_BAD_P1P2;
            else if (acc == (k ? `NPV_ACC_WLOCK : `NPV_ACC_RLOCK)) exp = `NPV_SW_COND;
            else if (lc == `NPV_LC_NONE) begin
                if (acc == `NPV_ACC_PWD && !gnt[k]) exp = `NPV_SW_PWD_REQ;
            end else if (lc != `NPV_LC_PWD) exp = `NPV_SW_BAD_DATA;
            else if (att == `NPV_RETRY_NONE) exp = `NPV_SW_SECURITY;
            else if (dat == pw[k]) gnt[k] = 1'b1;
            else begin
                att = att - 2'h1;
                exp = {`NPV_SW_BAD_PWD, 2'h0, att};
            end
        end else if (ins == `NPV_INS_CHANGE) begin
            if (!fileSelected) exp = `NPV_SW_NOT_FOUND;
            else if (!fileIsNdef) exp = `NPV_SW_INCOMPAT;
            else if (p12 != `NPV_P12_READ && !k) exp = `NPV_SW_BAD_P1P2;
            else if (lc != `NPV_LC_PWD) exp = `NPV_SW_BAD_DATA;
            else if (!gnt[1]) exp = `NPV_SW_SECURITY;
            else if (pwdStoreFail) exp = `NPV_SW_UPD_FAIL;
            else pw[k] = dat;
        end else exp = `NPV_SW_BAD_INS;
        reqData <= {cla, ins, p12, lc, dat};
        reqLen <= (lc == `NPV_LC_PWD) ? 5'h15 : 5'h05;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (int i = 0; i < 80 && rspValid_q !== 1'b1; i++) @(negedge core_clk);
        chk("answer", 16'h0001, {15'h0, rspValid_q});
        chk("sw", exp, {rspSw1_q, rspSw2_q});
        chk("grants", {14'h0, gnt}, {14'h0, grantWrite_q, grantRead_q});
        chk("attempts", {14'h0, att}, {14'h0, attemptsLeft_q});
    endtask : send

    // Watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge core_clk);
        numErrors++;
        closeOut();
    end

    // ****
    // Corner cases, then random traffic
    // ****
    initial begin
        logic [15:0] p;
        npv_pkg::npv_pwd_t nv;
        void'($urandom(26));
        pw[0] = '0;
        pw[1] = '0;
        gnt = 2'b00;
        att = `NPV_RETRY_MAX;
        nv = {$urandom, $urandom, $urandom, $urandom};
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        env(1'b1, 1'b1, 1'b1, 8'h80, 8'h80, 1'b0);
        send(8'h00, `NPV_INS_VERIFY, `NPV_P12_WRITE, `NPV_LC_NONE, '0);
        repeat (4) send(8'h00, `NPV_INS_VERIFY, `NPV_P12_WRITE, `NPV_LC_PWD, ~nv);
        send(8'h00, `NPV_INS_CHANGE, `NPV_P12_WRITE, `NPV_LC_PWD, nv);
        env(1'b1, 1'b1, 1'b1, 8'h80, 8'h80, 1'b0);
        send(8'h00, `NPV_INS_VERIFY, `NPV_P12_WRITE, `NPV_LC_PWD, pw[1]);
        send(8'h00, `NPV_INS_VERIFY, `NPV_P12_WRITE, `NPV_LC_NONE, '0);
        send(8'h00, `NPV_INS_CHANGE, `NPV_P12_WRITE, `NPV_LC_PWD, nv);
        send(8'h00, `NPV_INS_CHANGE, 16'h0003, `NPV_LC_PWD, nv);
        send(8'h00, `NPV_INS_CHANGE, `NPV_P12_READ, `NPV_LC_NONE, nv);
        @(posedge core_clk) pwdStoreFail <= 1'b1;
        send(8'h00, `NPV_INS_CHANGE, `NPV_P12_READ, `NPV_LC_PWD, ~nv);
        env(1'b1, 1'b1, 1'b1, 8'h80, 8'h80, 1'b0);
        send(8'h00, `NPV_INS_VERIFY, `NPV_P12_WRITE, `NPV_LC_PWD, nv);
        send(8'h00, `NPV_INS_VERIFY, `NPV_P12_READ, 8'h08, nv);
        // Request cut after three bytes must be refused as too short
        @(posedge core_clk);
        reqLen <= 5'h03;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (int i = 0; i < 80 && rspValid_q !== 1'b1; i++) @(negedge core_clk);
        chk("short", `NPV_SW_WRONG_LEN, {rspSw1_q, rspSw2_q});
        for (int n = 0; n < 300; n++) begin
            p = 16'($urandom_range(3));
            if ($urandom_range(3) == 0) env($urandom_range(3) == 0, $urandom_range(7) != 0,
                $urandom_range(7) != 0, accR[$urandom_range(2)], accW[$urandom_range(2)],
                $urandom_range(3) == 0);
            @(posedge core_clk) slow <= 1'($urandom_range(1));
            send(($urandom_range(15) == 0) ? 8'h80 : 8'h00, insT[$urandom_range(2)], p,
                ($urandom_range(4) == 0) ? `NPV_LC_NONE : `NPV_LC_PWD,
                $urandom_range(1) ? pw[p == 16'h2] : {$urandom, $urandom, $urandom, $urandom});
        end
        closeOut();
    end
endmodule : tb_npv_ndef_pwd

`default_nettype wire

// file: hw/npv_ndef_pwd.sv
// What this block does
// - Verify uses class 00h, instruction 20h, two parameter bytes, length, data.
// - Zero-length Verify on an unprotected file answers 90 00.
// - Zero-length Verify on a protected file answers 63 00 until its password has been verified, then 90 00.
// - Length 10h Verify compares sixteen bytes with the chosen stored password.
// - Verify checks access bytes of the most recently selected NDEF file.
// - A successful Verify grants access to the whole selected file.
// - Matching password answers 90 00.
// - No file selected, write FFh or read FEh lock answers 69 84.
// - Wrong password answers 63 CX, X being attempts still allowed.
// - At most three failed password checks per session, count drops on each failure.
// - Verify errors: 69 81 structure, 69 82 security, 6A 80 data field.
// - Change Reference Data replaces read or write password of selected file.
// - Change uses class 00h, instruction 24h, length 10h, sixteen new bytes.
// - Parameter 0001h picks read, 0002h write password, others give error.
// - Change runs only with security satisfied, otherwise answers 69 82.
// - Change answers 90 00 when done, 65 81 when the store fails.
// - Change errors: 6A 86 parameters, 6A 82 no file, 6A 80, 69 81.
// - Each read or write password is 128 bits wide.
`include "npv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module npv_ndef_pwd #(
    parameter int PWD_W = 128,
    parameter logic [PWD_W-1:0] READ_DEF = '0,
    parameter logic [PWD_W-1:0] WRITE_DEF = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sessionStart,
    input wire logic fileSelEvent,
    input wire logic fileSelected,
    input wire logic fileIsNdef,
    input wire logic [7:0] readAccess,
    input wire logic [7:0] writeAccess,
    input wire logic pwdStoreFail,
    input wire logic apduValid,
    input wire logic [7:0] apduByte,
    input wire logic apduLast,
    output logic apduReady_q,
    output logic rspValid_q,
    output logic [7:0] rspSw1_q,
    output logic [7:0] rspSw2_q,
    output logic grantRead_q,
    output logic grantWrite_q,
    output logic [1:0] attemptsLeft_q
);

    // ****************************************
    // Request capture
    // ****************************************
    npv_pkg::npv_state_e state_q;
    npv_pkg::npv_state_e state_d;
    logic [8:0] byteCnt_q;
    logic [7:0] cla_q;
    logic [7:0] ins_q;
    logic [15:0] p12_q;
    logic [7:0] lc_q;
    logic [PWD_W-1:0] dataBuf_q;
    logic [PWD_W-1:0] memRdData;

    wire logic takeByte = (state_q == npv_pkg::NPV_COLL) && apduValid;
    wire logic inData = (byteCnt_q >= `NPV_IDX_DATA);
    wire logic [8:0] byteCntInc = (byteCnt_q == `NPV_IDX_SAT) ? byteCnt_q
                                  : byteCnt_q + 9'h001;

    // Byte counter restarts after each request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            byteCnt_q <= 9'h000;
        end else if (state_q != npv_pkg::NPV_COLL) begin
            byteCnt_q <= 9'h000;
        end else if (apduValid) begin
            byteCnt_q <= byteCntInc;
        end
    end

    // Header fields by position
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cla_q <= 8'h00;
            ins_q <= 8'h00;
            p12_q <= 16'h0000;
            lc_q <= 8'h00;
        end else if (takeByte) begin
            if (byteCnt_q == `NPV_IDX_CLA) cla_q <= apduByte;
            if (byteCnt_q == `NPV_IDX_INS) ins_q <= apduByte;
            if (byteCnt_q == `NPV_IDX_P1) p12_q[15:8] <= apduByte;
            if (byteCnt_q == `NPV_IDX_P2) p12_q[7:0] <= apduByte;
            if (byteCnt_q == `NPV_IDX_LC) lc_q <= apduByte;
        end
    end

    // Data bytes shift in, first byte ends up most significant
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dataBuf_q <= '0;
        end else if (takeByte && inData) begin
            dataBuf_q <= {dataBuf_q[PWD_W-9:0], apduByte};
        end
    end

    // ****************************************
    // Request decode
    // ****************************************
    wire logic lenShort = (byteCnt_q < `NPV_IDX_DATA);
    wire logic lenMatch = (byteCnt_q == ({1'b0, lc_q} + `NPV_IDX_DATA));
    wire logic isVerify = (ins_q == `NPV_INS_VERIFY);
    wire logic isChange = (ins_q == `NPV_INS_CHANGE);
    wire logic claOk = (cla_q == `NPV_CLA_ISO);
    wire logic p12Read = (p12_q == `NPV_P12_READ);
    wire logic p12Write = (p12_q == `NPV_P12_WRITE);
    wire logic p12Ok = p12Read || p12Write;
    wire logic lcNone = (lc_q == `NPV_LC_NONE);
    wire logic lcPwd = (lc_q == `NPV_LC_PWD);

    // Access condition of the chosen password kind
    wire logic [7:0] selAcc = p12Read ? readAccess : writeAccess;
    wire logic selLocked = p12Read ? (readAccess == `NPV_ACC_RLOCK)
                           : (writeAccess == `NPV_ACC_WLOCK);
    wire logic selProt = (selAcc == `NPV_ACC_PWD);
    wire logic selGranted = p12Read ? grantRead_q : grantWrite_q;
    wire logic noRetry = (attemptsLeft_q == `NPV_RETRY_NONE);

    // ****************************************
    // Verify outcome before the compare
    // ****************************************
    logic [15:0] verifySw;
    logic verifyCmp;
    always_comb begin
        verifyCmp = 1'b0;
        if (!fileSelected) begin
            verifySw = `NPV_SW_COND;
        end else if (!fileIsNdef) begin
            verifySw = `NPV_SW_INCOMPAT;
        end else if (!p12Ok) begin
            verifySw = `NPV_SW_BAD_P1P2;
        end else if (selLocked) begin
            verifySw = `NPV_SW_COND;
        end else if (lcNone && lenMatch) begin
            verifySw = (selProt && !selGranted) ? `NPV_SW_PWD_REQ
                       : `NPV_SW_OK;
        end else if (lcPwd && lenMatch) begin
            verifySw = `NPV_SW_SECURITY;
            verifyCmp = !noRetry;
        end else begin
            verifySw = `NPV_SW_BAD_DATA;
        end
    end

    // ****************************************
    // Change outcome
    // ****************************************
    logic [15:0] changeSw;
    logic changeWr;
    always_comb begin
        changeWr = 1'b0;
        if (!fileSelected) begin
            changeSw = `NPV_SW_NOT_FOUND;
        end else if (!fileIsNdef) begin
            changeSw = `NPV_SW_INCOMPAT;
        end else if (!p12Ok) begin
            changeSw = `NPV_SW_BAD_P1P2;
        end else if (!lcPwd || !lenMatch) begin
            changeSw = `NPV_SW_BAD_DATA;
        end else if (!grantWrite_q) begin
            changeSw = `NPV_SW_SECURITY;
        end else if (pwdStoreFail) begin
            changeSw = `NPV_SW_UPD_FAIL;
        end else begin
            changeSw = `NPV_SW_OK;
            changeWr = 1'b1;
        end
    end

    // Top-level selection of the answer in the evaluate cycle
    wire logic [15:0] evalSw = lenShort ? `NPV_SW_WRONG_LEN
                               : !claOk ? `NPV_SW_BAD_CLA
                               : isVerify ? verifySw
                               : isChange ? changeSw
                               : `NPV_SW_BAD_INS;
    wire logic inEval = (state_q == npv_pkg::NPV_EVAL);
    wire logic inCmp = (state_q == npv_pkg::NPV_CMP);
    wire logic wantCmp = !lenShort && claOk && isVerify && verifyCmp;
    wire logic memWr = inEval && !lenShort && claOk && isChange && changeWr;

    // ****************************************
    // Password compare
    // ****************************************
    wire logic pwdMatch = (memRdData == dataBuf_q);
    wire logic [1:0] attemptsDec = attemptsLeft_q - `NPV_RETRY_ONE;
    wire logic [15:0] cmpSw = pwdMatch ? `NPV_SW_OK
                              : {`NPV_SW_BAD_PWD, 2'b00, attemptsDec};
    wire logic cmpOk = inCmp && pwdMatch;
    wire logic cmpFail = inCmp && !pwdMatch;

    npv_pwd_mem #(
        .WIDTH(PWD_W),
        .READ_DEF(READ_DEF),
        .WRITE_DEF(WRITE_DEF)
    ) u_mem (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(memWr),
        .wrIdx(p12Write),
        .wrData(dataBuf_q),
        .rdIdx(p12Write),
        .rdData_q(memRdData)
    );

    // ****************************************
    // Sequencing
    // ****************************************
    always_comb begin
        case (state_q)
            npv_pkg::NPV_COLL: begin
                state_d = (apduValid && apduLast) ? npv_pkg::NPV_EVAL
                          : npv_pkg::NPV_COLL;
            end
            npv_pkg::NPV_EVAL: begin
                state_d = wantCmp ? npv_pkg::NPV_CMP : npv_pkg::NPV_COLL;
            end
            npv_pkg::NPV_CMP: begin
                state_d = npv_pkg::NPV_COLL;
            end
            default: begin
                state_d = npv_pkg::NPV_COLL;
            end
        endcase
    end

    // State register and ready flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= npv_pkg::NPV_COLL;
            apduReady_q <= 1'b1;
        end else begin
            state_q <= state_d;
            apduReady_q <= (state_d == npv_pkg::NPV_COLL);
        end
    end

    // ****************************************
    // Response
    // ****************************************
    wire logic rspNow = (inEval && !wantCmp) || inCmp;
    wire logic [15:0] rspSw = inCmp ? cmpSw : evalSw;

    // Status word holds until the next answer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rspValid_q <= 1'b0;
            rspSw1_q <= 8'h00;
            rspSw2_q <= 8'h00;
        end else begin
            rspValid_q <= rspNow;
            if (rspNow) begin
                rspSw1_q <= rspSw[15:8];
                rspSw2_q <= rspSw[7:0];
            end
        end
    end

    // ****************************************
    // Session state
    // ****************************************
    // Attempt budget, refilled at session start, failure wins the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            attemptsLeft_q <= `NPV_RETRY_MAX;
        end else if (cmpFail) begin
            attemptsLeft_q <= attemptsDec;
        end else if (sessionStart) begin
            attemptsLeft_q <= `NPV_RETRY_MAX;
        end
    end

    // File-wide grants; a new grant wins over a clear in the same cycle
    wire logic grantClr = sessionStart || fileSelEvent;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            grantRead_q <= 1'b0;
            grantWrite_q <= 1'b0;
        end else begin
            if (cmpOk && p12Read) begin
                grantRead_q <= 1'b1;
            end else if (grantClr) begin
                grantRead_q <= 1'b0;
            end
            if (cmpOk && p12Write) begin
                grantWrite_q <= 1'b1;
            end else if (grantClr) begin
                grantWrite_q <= 1'b0;
            end
        end
    end

endmodule : npv_ndef_pwd

`default_nettype wire

// file: hw/npv_pwd_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Password store with registered read
// ****************************************
module npv_pwd_mem #(
    parameter int WIDTH = 128,
    parameter logic [WIDTH-1:0] READ_DEF = '0,
    parameter logic [WIDTH-1:0] WRITE_DEF = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic wrIdx,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic rdIdx,
    output logic [WIDTH-1:0] rdData_q
);

    logic [WIDTH-1:0] mem_q [0:1];

    // Array loads its defaults at reset, then takes writes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_q[0] <= READ_DEF;
            mem_q[1] <= WRITE_DEF;
        end else if (wrEn) begin
            mem_q[wrIdx] <= wrData;
        end
    end

    // Read data always comes out of a register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= mem_q[rdIdx];
        end
    end

endmodule : npv_pwd_mem

`default_nettype wire

// file: inc/npv_pkg.sv
package npv_pkg;

    // Command interpreter states
    typedef enum logic [1:0] {
        NPV_COLL = 2'b00,
        NPV_EVAL = 2'b01,
        NPV_CMP = 2'b10
    } npv_state_e;

    // One stored password
    typedef logic [127:0] npv_pwd_t;

endpackage : npv_pkg

// file: inc/npv_regs.svh
`ifndef NPV_REGS_SVH
`define NPV_REGS_SVH

// ****************************************
// Command header values
// ****************************************
`define NPV_CLA_ISO 8'h00
`define NPV_INS_VERIFY 8'h20
`define NPV_INS_CHANGE 8'h24
`define NPV_LC_NONE 8'h00
`define NPV_LC_PWD 8'h10
`define NPV_P12_READ 16'h0001
`define NPV_P12_WRITE 16'h0002

// ****************************************
// Byte positions inside a request
// ****************************************
`define NPV_IDX_CLA 9'h000
`define NPV_IDX_INS 9'h001
`define NPV_IDX_P1 9'h002
`define NPV_IDX_P2 9'h003
`define NPV_IDX_LC 9'h004
`define NPV_IDX_DATA 9'h005
`define NPV_IDX_SAT 9'h1FF

// ****************************************
// Access condition bytes
// ****************************************
`define NPV_ACC_PWD 8'h80
`define NPV_ACC_RLOCK 8'hFE
`define NPV_ACC_WLOCK 8'hFF

// ****************************************
// Status words
// ****************************************
`define NPV_SW_OK 16'h9000
`define NPV_SW_PWD_REQ 16'h6300
`define NPV_SW_BAD_PWD 12'h63C
`define NPV_SW_COND 16'h6984
`define NPV_SW_INCOMPAT 16'h6981
`define NPV_SW_SECURITY 16'h6982
`define NPV_SW_BAD_DATA 16'h6A80
`define NPV_SW_NOT_FOUND 16'h6A82
`define NPV_SW_BAD_P1P2 16'h6A86
`define NPV_SW_UPD_FAIL 16'h6581
`define NPV_SW_WRONG_LEN 16'h6700
`define NPV_SW_BAD_INS 16'h6D00
`define NPV_SW_BAD_CLA 16'h6E00

// ****************************************
// Retry budget and password slots
// ****************************************
`define NPV_RETRY_MAX 2'h3
`define NPV_RETRY_NONE 2'h0
`define NPV_RETRY_ONE 2'h1
`define NPV_SLOT_READ 1'b0
`define NPV_SLOT_WRITE 1'b1

`endif
